/* File: core/csp_pkg.sv */
// Shared constants for the converter stream pipe
`default_nettype none
package csp_pkg;
  // Channel counts and widths
  localparam int NCH         = 8;
  localparam int SELW        = 3;
  localparam int DAC_DATA_W  = 128;
  localparam int ADC_IN_W    = 128;
  localparam int ADC_OUT_W   = 256;
  localparam int FIFO_DEPTH  = 16;
  localparam int APB_AW      = 8;
  localparam int APB_DW      = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_DAC_CNT0 = 8'h00;
  localparam logic [7:0] OFF_ADC_CNT0 = 8'h20;
  localparam logic [7:0] OFF_DAC_GATE = 8'h40;
  localparam logic [7:0] OFF_DAC_LOOP = 8'h44;
  localparam logic [7:0] OFF_DAC_SW   = 8'h48;
  localparam logic [7:0] OFF_DAC_ARB  = 8'h4c;
  localparam logic [7:0] OFF_ADC_CTRL = 8'h50;
  // Field positions
  localparam int ARB_MASK_LSB   = 0;
  localparam int ARB_DDR_BIT    = 8;
  localparam int ARB_BSEL_LSB   = 16;
  localparam int ARB_GRANT_LSB  = 24;
  localparam int ARB_GVALID_BIT = 27;
  localparam int ADC_EN_LSB     = 0;
  localparam int ADC_CPLX_LSB   = 8;
  localparam int ADC_GSTART_BIT = 16;
  localparam int ADC_SEL_LSB    = 20;
  // Reset values
  localparam logic [NCH-1:0]  RST_MASK = 8'h00;
  localparam logic [SELW-1:0] RST_SEL  = 3'h0;
endpackage
`default_nettype wire

/* File: core/csp_stream_if.sv */
// Stream carrier between the pipe's own modules
`default_nettype none
interface csp_stream_if #(parameter int W = 8);
  logic [W-1:0] tdata;
  logic         tvalid;
  logic         tlast;
  logic         tready;
  modport src (output tdata, output tvalid, output tlast, input tready);
  modport snk (input tdata, input tvalid, input tlast, output tready);
endinterface
`default_nettype wire

/* File: core/csp_fifo.sv */
// Channel stream FIFO with fill count
`default_nettype none
module csp_fifo
  import csp_pkg::*;
#(
  parameter int W     = DAC_DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic    i_clk,
  input  wire logic    i_resetn,
  // Streams
  csp_stream_if.snk    s_in,
  csp_stream_if.src    s_out,
  // Fill level
  output logic [CW-1:0] o_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W:0]    mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic          push;
  logic          pop;

  assign pop          = s_out.tvalid & s_out.tready;
  assign push         = s_in.tvalid & s_in.tready;
  assign s_out.tvalid = (o_count != '0);
  // A pop in the same cycle frees a slot, so recirculation never stalls
  assign s_in.tready  = (o_count < CW'(DEPTH)) | pop;
  assign s_out.tdata  = mem[rd_ptr][W-1:0];
  assign s_out.tlast  = mem[rd_ptr][W];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= {s_in.tlast, s_in.tdata};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      o_count <= o_count + CW'(push) - CW'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_count <= CW'(DEPTH)) and ((pop && !push) |=> o_count == $past(o_count) - CW'(1)))
    else $error("fifo count out of step");
endmodule
`default_nettype wire

/* File: core/csp_adc_merge.sv */
// ADC channel gate with I/Q merge or real width conversion
`default_nettype none
module csp_adc_merge
  import csp_pkg::*;
#(
  parameter int IW = ADC_IN_W
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Controls
  input  wire logic i_en,
  input  wire logic i_complex,
  // Streams
  csp_stream_if.snk s_i,
  csp_stream_if.snk s_q,
  csp_stream_if.src s_out
);
  logic [IW-1:0] low_half;
  logic          half;
  logic          i_hs;

  always_comb begin
    if (i_complex) begin
      // Combiner: I and Q move together so the pair stays coherent
      s_out.tvalid = i_en & s_i.tvalid & s_q.tvalid;
      s_out.tdata  = {s_q.tdata, s_i.tdata};
      s_i.tready   = i_en & s_out.tready & s_q.tvalid;
      s_q.tready   = i_en & s_out.tready & s_i.tvalid;
    end else begin
      s_out.tvalid = i_en & s_i.tvalid & half;
      s_out.tdata  = {s_i.tdata, low_half};
      s_i.tready   = i_en & (~half | s_out.tready);
      s_q.tready   = i_en;
    end
    s_out.tlast = s_i.tlast;
  end

  assign i_hs = s_i.tvalid & s_i.tready;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half     <= 1'b0;
      low_half <= '0;
    end else if (i_complex) begin
      half <= 1'b0;
    end else if (i_hs) begin
      if (!half) begin
        low_half <= s_i.tdata;
      end
      half <= ~half;
    end
  end

  adc_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_en |-> (!s_out.tvalid && !s_i.tready && !s_q.tready))
    else $error("adc gate passed data while stopped");

  iq_pair_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_complex && s_out.tvalid && s_out.tready) |-> (s_i.tready && s_q.tready))
    else $error("i and q not consumed together");

  width_pair_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!i_complex && !half && i_hs) |=> (!s_out.tvalid || s_out.tdata[IW-1:0] == $past(s_i.tdata)))
    else $error("width converter lost first half");
endmodule
`default_nettype wire

/* File: core/csp_top.sv */
// Converter stream pipe: DAC distribution, ADC capture and APB control
//
// The address map and the APB interface to the registers were left to the implementer.
`default_nettype none
// What this block does
// - Broadcast DMA data unchanged to every DAC pipe not in loopback replay
// - Pipe valid is DMA valid AND channel control
// - Control from software in BRAM, arbiter in DDR
// - Arbiter samples selection, round robin on TLAST
// - Only selected channel's ready returns to DMA
// - Each DAC pipe buffers through a stream FIFO
// - After FIFO choose loopback replay or DDR forward
// - DAC switch gates valid and ready while enabled
// - Every channel has its own start/stop control
// - ADC switch gates converter valid and ready
// - Shared global start enables every ADC channel whose adc_en bit is set
// - Per channel choose real or complex stream
// - Complex merge: eight I then eight Q, coherent
// - Real mode widens 128-bit input to 256 bits
// - One ADC FIFO selected to the DMA
// - Eight DAC and eight ADC channels at once
// - ADC runs in real mode by default (adc_cplx resets to zero, Q is not used)
// - ADC select is a three-bit field
module csp_top
  import csp_pkg::*;
#(
  parameter int DAC_W = DAC_DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  // APB slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [APB_AW-1:0]             i_paddr,
  input  wire logic [APB_DW-1:0]             i_pwdata,
  output logic      [APB_DW-1:0]             o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // DMA stream toward the DACs
  input  wire logic [DAC_W-1:0]              i_mm2s_tdata,
  input  wire logic                          i_mm2s_tvalid,
  input  wire logic                          i_mm2s_tlast,
  output logic                               o_mm2s_tready,
  // DAC channel streams
  output logic      [NCH-1:0][DAC_W-1:0]     o_dac_tdata,
  output logic      [NCH-1:0]                o_dac_tvalid,
  output logic      [NCH-1:0]                o_dac_tlast,
  input  wire logic [NCH-1:0]                i_dac_tready,
  // ADC channel I and Q streams
  input  wire logic [NCH-1:0][ADC_IN_W-1:0]  i_adc_i_tdata,
  input  wire logic [NCH-1:0]                i_adc_i_tvalid,
  input  wire logic [NCH-1:0]                i_adc_i_tlast,
  output logic      [NCH-1:0]                o_adc_i_tready,
  input  wire logic [NCH-1:0][ADC_IN_W-1:0]  i_adc_q_tdata,
  input  wire logic [NCH-1:0]                i_adc_q_tvalid,
  input  wire logic [NCH-1:0]                i_adc_q_tlast,
  output logic      [NCH-1:0]                o_adc_q_tready,
  // ADC stream toward the DMA
  output logic      [ADC_OUT_W-1:0]          o_s2mm_tdata,
  output logic                               o_s2mm_tvalid,
  output logic                               o_s2mm_tlast,
  input  wire logic                          i_s2mm_tready
);
  localparam int CW = $clog2(DEPTH + 1);

  // Control registers
  logic [NCH-1:0]  dac_gate_sw;
  logic [NCH-1:0]  dac_loop;
  logic [NCH-1:0]  dac_switch;
  logic            ddr_mode;
  logic [SELW-1:0] bram_sel;
  logic [NCH-1:0]  adc_en;
  logic [NCH-1:0]  adc_cplx;
  logic            global_start;
  logic [SELW-1:0] adc_sel;
  // Arbiter state
  logic [NCH-1:0]  arb_mask;
  logic [SELW-1:0] grant;
  logic            grant_valid;
  // Datapath helpers
  logic [NCH-1:0]            dac_gate;
  logic [NCH-1:0]            recirc;
  logic [NCH-1:0]            ch_ready;
  logic [NCH-1:0]            dac_wr_valid;
  logic [NCH-1:0][DAC_W-1:0] dac_wr_data;
  logic [NCH-1:0][CW-1:0]    dac_cnt;
  logic [NCH-1:0][CW-1:0]    adc_cnt;
  logic [NCH-1:0]            adc_fv;
  logic [NCH-1:0]            adc_fl;
  logic [NCH-1:0][ADC_OUT_W-1:0] adc_fd;
  logic [SELW-1:0]           ready_sel;
  logic                      sel_live;
  logic                      dma_last_hs;
  // Bus helpers
  logic [APB_DW-1:0]         rd_word;
  logic                      mapped;
  logic                      wr_en;
  logic [7:0]                addr8;

  // Round-robin search for the next active channel after 'from'
  function automatic logic [SELW-1:0] rr_next(input logic [NCH-1:0] mask,
                                              input logic [SELW-1:0] from);
    logic [SELW-1:0] res;
    logic            found;
    int              idx;
    res   = from;
    found = 1'b0;
    idx   = 0;
    for (int k = 1; k <= NCH; k++) begin
      idx = (int'(from) + k) % NCH;
      if (!found && mask[idx]) begin
        res   = SELW'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // APB decode
  assign addr8     = 8'(i_paddr);
  assign mapped    = (addr8[1:0] == 2'h0) && (addr8 <= OFF_ADC_CTRL);
  assign wr_en     = i_psel & i_penable & i_pwrite & mapped;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  always_comb begin
    rd_word = '0;
    if (!mapped) begin
      rd_word = '0;
    end else if (addr8 < OFF_ADC_CNT0) begin
      rd_word = APB_DW'(dac_cnt[addr8[4:2]]);
    end else if (addr8 < OFF_DAC_GATE) begin
      rd_word = APB_DW'(adc_cnt[addr8[4:2]]);
    end else begin
      unique case (addr8)
        OFF_DAC_GATE: rd_word[NCH-1:0] = dac_gate_sw;
        OFF_DAC_LOOP: rd_word[NCH-1:0] = dac_loop;
        OFF_DAC_SW:   rd_word[NCH-1:0] = dac_switch;
        OFF_DAC_ARB: begin
          rd_word[ARB_MASK_LSB +: NCH]   = arb_mask;
          rd_word[ARB_DDR_BIT]           = ddr_mode;
          rd_word[ARB_BSEL_LSB +: SELW]  = bram_sel;
          rd_word[ARB_GRANT_LSB +: SELW] = grant;
          rd_word[ARB_GVALID_BIT]        = grant_valid;
        end
        OFF_ADC_CTRL: begin
          rd_word[ADC_EN_LSB +: NCH]    = adc_en;
          rd_word[ADC_CPLX_LSB +: NCH]  = adc_cplx;
          rd_word[ADC_GSTART_BIT]       = global_start;
          rd_word[ADC_SEL_LSB +: SELW]  = adc_sel;
        end
        default: rd_word = '0;
      endcase
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rd_word;
    end
  end

  // Software controls
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dac_gate_sw  <= RST_MASK;
      dac_loop     <= RST_MASK;
      dac_switch   <= RST_MASK;
      ddr_mode     <= 1'b0;
      bram_sel     <= RST_SEL;
      adc_en       <= RST_MASK;
      adc_cplx     <= RST_MASK;
      global_start <= 1'b0;
      adc_sel      <= RST_SEL;
    end else if (wr_en) begin
      unique case (addr8)
        OFF_DAC_GATE: dac_gate_sw <= i_pwdata[NCH-1:0];
        OFF_DAC_LOOP: dac_loop    <= i_pwdata[NCH-1:0];
        OFF_DAC_SW:   dac_switch  <= i_pwdata[NCH-1:0];
        OFF_DAC_ARB: begin
          ddr_mode <= i_pwdata[ARB_DDR_BIT];
          bram_sel <= i_pwdata[ARB_BSEL_LSB +: SELW];
        end
        OFF_ADC_CTRL: begin
          adc_en       <= i_pwdata[ADC_EN_LSB +: NCH];
          adc_cplx     <= i_pwdata[ADC_CPLX_LSB +: NCH];
          global_start <= i_pwdata[ADC_GSTART_BIT];
          adc_sel      <= i_pwdata[ADC_SEL_LSB +: SELW];
        end
        default: begin
        end
      endcase
    end
  end

  // DDR-mode channel arbiter
  assign dma_last_hs = i_mm2s_tvalid & o_mm2s_tready & i_mm2s_tlast;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arb_mask    <= RST_MASK;
      grant       <= RST_SEL;
      grant_valid <= 1'b0;
    end else if (wr_en && addr8 == OFF_DAC_ARB) begin
      arb_mask    <= i_pwdata[ARB_MASK_LSB +: NCH];
      grant       <= rr_next(i_pwdata[ARB_MASK_LSB +: NCH], SELW'(NCH - 1));
      grant_valid <= |i_pwdata[ARB_MASK_LSB +: NCH];
    end else if (ddr_mode && grant_valid && dma_last_hs) begin
      grant <= rr_next(arb_mask, grant);
    end
  end

  always_comb begin
    dac_gate = '0;
    if (ddr_mode) begin
      if (grant_valid) begin
        dac_gate[grant] = 1'b1;
      end
    end else begin
      dac_gate = dac_gate_sw;
    end
  end

  assign ready_sel     = ddr_mode ? grant : bram_sel;
  assign sel_live      = ddr_mode ? grant_valid : dac_gate_sw[bram_sel];
  assign o_mm2s_tready = sel_live & ch_ready[ready_sel];
  // Loopback replays only while the channel is running
  assign recirc        = dac_loop & dac_switch;

  // DAC channel pipes
  for (genvar c = 0; c < NCH; c++) begin : g_dac
    csp_stream_if #(.W(DAC_W)) f_in ();
    csp_stream_if #(.W(DAC_W)) f_out ();

    assign f_in.tdata   = recirc[c] ? f_out.tdata : i_mm2s_tdata;
    assign f_in.tlast   = recirc[c] ? f_out.tlast : i_mm2s_tlast;
    assign f_in.tvalid  = recirc[c] ? (f_out.tvalid & f_out.tready)
                                    : (i_mm2s_tvalid & dac_gate[c]);
    assign ch_ready[c]  = f_in.tready & ~recirc[c];
    assign f_out.tready = i_dac_tready[c] & dac_switch[c];
    assign o_dac_tvalid[c] = f_out.tvalid & dac_switch[c];
    assign o_dac_tdata[c]  = f_out.tdata;
    assign o_dac_tlast[c]  = f_out.tlast;
    assign dac_wr_valid[c] = f_in.tvalid;
    assign dac_wr_data[c]  = f_in.tdata;

    csp_fifo #(.W(DAC_W), .DEPTH(DEPTH), .CW(CW)) u_fifo (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .s_in     (f_in),
      .s_out    (f_out),
      .o_count  (dac_cnt[c])
    );
  end

  // ADC channel pipes
  for (genvar c = 0; c < NCH; c++) begin : g_adc
    csp_stream_if #(.W(ADC_IN_W))  s_i ();
    csp_stream_if #(.W(ADC_IN_W))  s_q ();
    csp_stream_if #(.W(ADC_OUT_W)) m_out ();
    csp_stream_if #(.W(ADC_OUT_W)) f_out ();

    assign s_i.tdata  = i_adc_i_tdata[c];
    assign s_i.tvalid = i_adc_i_tvalid[c];
    assign s_i.tlast  = i_adc_i_tlast[c];
    assign o_adc_i_tready[c] = s_i.tready;
    assign s_q.tdata  = i_adc_q_tdata[c];
    assign s_q.tvalid = i_adc_q_tvalid[c];
    assign s_q.tlast  = i_adc_q_tlast[c];
    assign o_adc_q_tready[c] = s_q.tready;
    assign f_out.tready = i_s2mm_tready & (adc_sel == SELW'(c));
    assign adc_fv[c] = f_out.tvalid;
    assign adc_fd[c] = f_out.tdata;
    assign adc_fl[c] = f_out.tlast;

    csp_adc_merge #(.IW(ADC_IN_W)) u_merge (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_en      (adc_en[c] & global_start),
      .i_complex (adc_cplx[c]),
      .s_i       (s_i),
      .s_q       (s_q),
      .s_out     (m_out)
    );

    csp_fifo #(.W(ADC_OUT_W), .DEPTH(DEPTH), .CW(CW)) u_fifo (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .s_in     (m_out),
      .s_out    (f_out),
      .o_count  (adc_cnt[c])
    );
  end

  assign o_s2mm_tvalid = adc_fv[adc_sel];
  assign o_s2mm_tdata  = adc_fd[adc_sel];
  assign o_s2mm_tlast  = adc_fl[adc_sel];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence last_beat_s;
    ddr_mode && grant_valid && dma_last_hs && !wr_en;
  endsequence

  bcast_data_a: assert property ((dac_wr_data[0] == i_mm2s_tdata || recirc[0])
    && (dac_wr_data[NCH-1] == i_mm2s_tdata || recirc[NCH-1]))
    else $error("dac broadcast data altered");

  valid_gate_a: assert property (!recirc[1] |->
    dac_wr_valid[1] == (i_mm2s_tvalid && dac_gate[1]))
    else $error("dac pipe valid not gated");

  mode_source_a: assert property (ddr_mode ?
    ($onehot0(dac_gate) && ((dac_gate != '0) == grant_valid)) : (dac_gate == dac_gate_sw))
    else $error("ddr gate without grant");

  rr_step_a: assert property (last_beat_s ##0 ($countones(arb_mask) > 1) |=>
    (grant != $past(grant)) && arb_mask[grant])
    else $error("arbiter did not move to next active channel");

  ready_pick_a: assert property (o_mm2s_tready == (dac_gate[ready_sel] && ch_ready[ready_sel]))
    else $error("dma ready from wrong channel");

  dac_stop_a: assert property (!dac_switch[0] |->
    !o_dac_tvalid[0] && !g_dac[0].f_out.tready)
    else $error("stopped dac channel passed data");

  adc_pick_a: assert property ((adc_sel == 3'h1) |->
    (o_s2mm_tvalid == adc_fv[1]) && !g_adc[0].f_out.tready)
    else $error("adc mux chose wrong fifo");

  reset_idle_a: assert property ($rose(i_resetn) |->
    (o_dac_tvalid == '0) && !o_mm2s_tready && (o_adc_i_tready == '0))
    else $error("streams active after reset");
endmodule
`default_nettype wire

/* File: verification/csp_conv_model.sv */
// Converter side model: DAC sink and ADC I/Q sources
`default_nettype none
module csp_conv_model
  import csp_pkg::*;
(
  // Control
  input  wire logic                         i_clk,
  input  wire logic                         i_ready,
  input  wire logic [NCH-1:0]               i_go,
  // DAC sink
  output logic      [NCH-1:0]               o_dac_tready,
  // ADC sources
  output logic      [NCH-1:0][ADC_IN_W-1:0] o_i_data,
  output logic      [NCH-1:0]               o_i_valid,
  input  wire logic [NCH-1:0]               i_i_ready,
  output logic      [NCH-1:0][ADC_IN_W-1:0] o_q_data,
  output logic      [NCH-1:0]               o_q_valid,
  input  wire logic [NCH-1:0]               i_q_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NCH-1:0][7:0] ni = '0;
  logic [NCH-1:0][7:0] nq = '0;
  assign o_dac_tready = {NCH{i_ready}};
  assign o_i_valid    = i_go;
  assign o_q_valid    = i_go;
  // Idle lines show the inverse word so no stale value passes
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      o_i_data[c] = {112'h0, 8'(c), ni[c]} ^ {ADC_IN_W{!i_go[c]}};
      o_q_data[c] = {112'h0, 8'(c + 128), nq[c]} ^ {ADC_IN_W{!i_go[c]}};
    end
  end
  always @(posedge i_clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (i_go[c] && i_i_ready[c])
        ni[c] <= ni[c] + 8'h01;
      if (i_go[c] && i_q_ready[c])
        nq[c] <= nq[c] + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verification/csp_top_test.sv */
// Self-checking bench for the converter stream pipe
`default_nettype none
module csp_top_test
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           clk = 0;
  logic                           rst_n = 0;
  logic                           psel = 0;
  logic                           pen = 0;
  logic                           pwr = 0;
  logic [APB_AW-1:0]              paddr = '0;
  logic [APB_DW-1:0]              pwd = '0;
  logic [APB_DW-1:0]              prd;
  logic [APB_DW-1:0]              rd;
  logic                           prdy;
  logic                           perr;
  logic [DAC_DATA_W-1:0]          md = '0;
  logic                           mv = 0;
  logic                           ml = 0;
  logic                           mr;
  logic [NCH-1:0][DAC_DATA_W-1:0] dd;
  logic [NCH-1:0][ADC_IN_W-1:0]   id;
  logic [NCH-1:0][ADC_IN_W-1:0]   qd;
  logic [NCH-1:0]                 dv, dl, dr, iv, ir, qv, qr;
  logic [NCH-1:0]                 go = '0;
  logic [ADC_OUT_W-1:0]           sd;
  logic                           sv, sl;
  logic                           crdy = 0;
  logic                           srdy = 0;
  int                             fails = 0;
  int                             checks = 0;
  always #5 clk = ~clk;

  csp_top #(.DEPTH(4)) csp_top_inst (
    .i_clk(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_mm2s_tdata(md), .i_mm2s_tvalid(mv),
    .i_mm2s_tlast(ml), .o_mm2s_tready(mr), .o_dac_tdata(dd), .o_dac_tvalid(dv),
    .o_dac_tlast(dl), .i_dac_tready(dr), .i_adc_i_tdata(id), .i_adc_i_tvalid(iv),
    .i_adc_i_tlast('0), .o_adc_i_tready(ir), .i_adc_q_tdata(qd),
    .i_adc_q_tvalid(qv), .i_adc_q_tlast('0), .o_adc_q_tready(qr),
    .o_s2mm_tdata(sd), .o_s2mm_tvalid(sv), .o_s2mm_tlast(sl), .i_s2mm_tready(srdy));
  csp_conv_model csp_conv_model_inst (
    .i_clk(clk), .i_ready(crdy), .i_go(go), .o_dac_tready(dr), .o_i_data(id),
    .o_i_valid(iv), .i_i_ready(ir), .o_q_data(qd), .o_q_valid(qv), .i_q_ready(qr));

  function automatic logic [127:0] w(int c, int n, logic q);
    return {112'h0, q, 7'(c), 8'(n)};
  endfunction
  task automatic check(input logic [ADC_OUT_W-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= wr;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    rd = prd;
    check(prdy, 1'b1);
    check(perr, e);
    psel <= 0;
    pen <= 0;
  endtask
  task automatic beat(input logic [127:0] d, input logic l);
    int n;
    @(posedge clk);
    md <= d;
    mv <= 1;
    ml <= l;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mr !== 1'b1 && n < 50);
    check(mr, 1'b1);
    @(posedge clk);
    mv <= 0;
  endtask
  task automatic cnt(input int c, input int e);
    apb(0, OFF_DAC_CNT0 + 8'(4 * c), '0, 0);
    check(rd, e);
  endtask
  task automatic t_reset();
    check({mr, dv}, '0);
    apb(0, OFF_DAC_ARB, '0, 0);
    check(rd, '0);
    apb(0, 8'h54, '0, 1);
    apb(0, 8'h42, '0, 1);
    check(rd, '0);
  endtask
  task automatic t_bram();
    apb(1, OFF_DAC_GATE, 32'h05, 0);
    apb(1, OFF_DAC_ARB, 32'h0002_0000, 0);
    beat({4{32'hcafe_0001}}, 0);
    for (int c = 0; c < 3; c++)
      cnt(c, c == 1 ? 0 : 1);
    apb(1, OFF_DAC_ARB, 32'h0001_0000, 0);
    @(negedge clk);
    check(mr, 1'b0);
    apb(1, OFF_DAC_SW, 32'h01, 0);
    @(negedge clk);
    check(dv, 8'h01);
    check(dd[0], {4{32'hcafe_0001}});
    apb(1, OFF_DAC_LOOP, 32'h04, 0);
    apb(1, OFF_DAC_SW, 32'h05, 0);
    crdy <= 1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(dv, 8'h04);
    check(dd[2], {4{32'hcafe_0001}});
    cnt(2, 1);
    apb(1, OFF_DAC_SW, 32'h00, 0);
    apb(1, OFF_DAC_LOOP, 32'h00, 0);
  endtask
  task automatic t_ddr();
    apb(1, OFF_DAC_ARB, 32'h0000_010a, 0);
    apb(0, OFF_DAC_ARB, '0, 0);
    check(rd[27:24], 4'h9);
    beat({4{32'h0000_1111}}, 1);
    apb(0, OFF_DAC_ARB, '0, 0);
    check(rd[27:24], 4'hb);
    beat({4{32'h0000_3333}}, 1);
    apb(0, OFF_DAC_ARB, '0, 0);
    check(rd[27:24], 4'h9);
    cnt(0, 0);
    cnt(1, 1);
    cnt(3, 1);
    check({dl[3], dl[1]}, 2'b11);
  endtask
  task automatic t_adc();
    int n;
    go <= 8'h03;
    apb(1, OFF_ADC_CTRL, 32'h01, 0);
    repeat (3) @(posedge clk);
    check(ir[0], 1'b0);
    apb(0, OFF_ADC_CNT0, '0, 0);
    check(rd, '0);
    apb(1, OFF_ADC_CTRL, 32'h0001_0001, 0);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sv !== 1'b1 && n < 50);
    check(sd, {w(0, 1, 0), w(0, 0, 0)});
    check(qr, 8'h01);
    apb(1, OFF_ADC_CTRL, 32'h0001_0202, 0);
    apb(1, OFF_ADC_CTRL, 32'h0011_0202, 0);
    @(negedge clk);
    check({sl, sv}, 2'b01);
    check(sd, {w(1, 0, 1), w(1, 0, 0)});
    @(posedge clk);
    srdy <= 1;
    @(posedge clk);
    srdy <= 0;
    @(negedge clk);
    check(sd, {w(1, 1, 1), w(1, 1, 0)});
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_bram();
    t_ddr();
    t_adc();
    finish_test();
  end
endmodule
`default_nettype wire
